/* File: rtl/essi_index_select.sv */
// Egress statistics index selector: per-frame port and service counter
// indexes, colour, count decisions, protection index choice, counters.
// Assumes frame and lookup result arrive together in one cycle, and the
// register port follows the plain strobe protocol of the core.
//
// Contract
// - Port counter index from egress port and priority, colour as service.
// - Mode 0 with lookup enabled and base nonzero: base plus class offset.
// - Mode 0 without egress index: ingress index, top two bits dropped.
// - Modes 0 and 1: colour from drop level through the colour map.
// - Mode 1 like mode 0 but no service count without egress index.
// - Mode 2: ingress index, destination multicast bit as colour.
// - Mode 3: classified, pushed outer, or router leg VID as index.
// - Mode 3: top two VID bits dropped, multicast bit as colour.
// - Port count only for transmitted, non-extract frames.
// - Port counting applies to all egress port numbers.
// - Service count: physical port, transmitted, qualifies under mode.
// - Extracted frames counted only at or after extract count point.
// - Injected frames service-counted only at or before inject count point.
// - Late rewrite extract never updates service counters.
// - Abort counter on queue abort; lookup and software point aborts need the enable bit.
// - Protection flag presented as an egress lookup key field.
// - Protection select with flag set uses alternate indexes.
// - Each index holds 40-bit octet and 32-bit frame counters.
// - 17 counters per port, 2048 service counters.
// - Stacking disable with stacking headers suppresses service counts.
// - Abort enable covers lookup and software point discards only.
`default_nettype none

module essi_index_select
  import essi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire essi_frame_s frame,
  input wire essi_lookup_s lookup,
  output logic key_protection_active,
  output logic [11:0] sel_encapsulation_index,
  output logic [9:0] sel_maintenance_endpoint_index,
  output logic [SVC_BASE_W-1:0] sel_service_counter_base,
  output logic port_count,
  output logic [PORT_IDX_W-1:0] port_count_index,
  output logic service_count,
  output logic [SVC_IDX_W-1:0] service_count_index,
  output logic abort_count
);

  // ************************
  // Helpers
  // ************************
  function automatic logic is_extract_type(input essi_action_e act);
    is_extract_type = (act == ACT_EXTRACT) ||
                      (act == ACT_LATE_REWRITE_EXTRACT) ||
                      (act == ACT_UP_ENDPOINT_EXTRACT) ||
                      (act == ACT_LOOPBACK_ASSEMBLE);
  endfunction : is_extract_type

  function automatic logic is_port_config(input logic [7:0] addr);
    is_port_config = (addr[7:4] == ADDR_PORT_CONFIG_BASE[7:4]);
  endfunction : is_port_config

  // ************************
  // Configuration registers
  // ************************
  logic [1:0] mode_q;
  logic stack_dis_q;
  logic abort_ena_q;
  logic [3:0] drop_map_q;
  logic [31:0] class_offset_q;
  logic [12:0] cnt_sel_q;
  logic [PT_W-1:0] xtr_point_q [16];
  logic [PT_W-1:0] inj_point_q [16];
  logic [15:0] stack_hdr_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= COUNTER_CONTROL_RST[CC_MODE_LSB +: 2];
      stack_dis_q <= COUNTER_CONTROL_RST[CC_STACK_DIS_BIT];
      abort_ena_q <= COUNTER_CONTROL_RST[CC_ABORT_ENA_BIT];
      drop_map_q <= DROP_MAP_RST;
      class_offset_q <= CLASS_OFFSET_RST;
      cnt_sel_q <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        ADDR_COUNTER_CONTROL: begin
          mode_q <= reg_wdata[CC_MODE_LSB +: 2];
          stack_dis_q <= reg_wdata[CC_STACK_DIS_BIT];
          abort_ena_q <= reg_wdata[CC_ABORT_ENA_BIT];
        end
        ADDR_DROP_LEVEL_COLOUR_MAP: drop_map_q <= reg_wdata[3:0];
        ADDR_CLASS_OFFSET_TABLE: class_offset_q <= reg_wdata;
        ADDR_COUNTER_SELECT: cnt_sel_q <= reg_wdata[12:0];
        default: begin
        end
      endcase
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 16; gp++) begin : g_port_cfg
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          xtr_point_q[gp] <= XTR_POINT_RST;
          inj_point_q[gp] <= INJ_POINT_RST;
          stack_hdr_q[gp] <= 1'b0;
        end else if (reg_write && is_port_config(reg_addr) &&
                     reg_addr[3:0] == 4'(gp)) begin
          xtr_point_q[gp] <= reg_wdata[PC_XTR_LSB +: PT_W];
          inj_point_q[gp] <= reg_wdata[PC_INJ_LSB +: PT_W];
          stack_hdr_q[gp] <= reg_wdata[PC_STACK_HDR_BIT];
        end
      end
    end
  endgenerate

  // ************************
  // Protection index choice
  // ************************
  logic use_alt;
  logic [SVC_BASE_W-1:0] base_sel;

  assign use_alt = lookup.protection_sel && frame.protection_active_flag;
  assign base_sel = use_alt ? lookup.alt_service_counter_base :
                              lookup.service_counter_base;

  // ************************
  // Service index and colour
  // ************************
  logic egress_service_index_avail;
  logic [3:0] class_off;
  logic [11:0] vid_pick;
  logic dp_colour;
  logic mc_colour;
  logic [SVC_BASE_W-1:0] svc_idx;
  logic svc_colour;
  logic mode_ok;

  assign egress_service_index_avail = lookup.enabled && (base_sel != '0);
  assign class_off = class_offset_q[{frame.class_id, 2'b00} +: 4];
  assign dp_colour = drop_map_q[frame.drop_precedence];
  assign mc_colour = frame.dmac[40];

  assign vid_pick = frame.routed ? frame.router_leg_egress_vlan :
                    frame.tag_pushed ? frame.pushed_vid :
                    frame.classified_vid;

  always_comb begin
    // Top two ingress index bits are ignored
    svc_idx = frame.ingress_service_index[SVC_BASE_W-1:0];
    svc_colour = dp_colour;
    mode_ok = 1'b1;
    case (mode_q)
      2'd0, 2'd1: begin
        if (egress_service_index_avail) begin
          svc_idx = base_sel + SVC_BASE_W'(class_off);
        end else begin
          mode_ok = (mode_q == 2'd0);
        end
      end
      2'd2: begin
        svc_idx = frame.ingress_service_index[SVC_BASE_W-1:0];
        svc_colour = mc_colour;
      end
      2'd3: begin
        svc_idx = vid_pick[SVC_BASE_W-1:0];
        svc_colour = mc_colour;
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase
  end

  // ************************
  // Count decisions
  // ************************
  logic phys_port;
  logic point_ok;
  logic stack_ok;
  logic svc_hit;
  logic port_hit;
  logic abort_hit;
  logic [PORT_IDX_W-1:0] port_base;
  logic [PORT_IDX_W-1:0] port_idx;
  logic [PT_W-1:0] xtr_pt;
  logic [PT_W-1:0] inj_pt;

  assign phys_port = (frame.egress_port < PORT_W'(PHYS_PORTS));
  assign xtr_pt = xtr_point_q[frame.egress_port];
  assign inj_pt = inj_point_q[frame.egress_port];
  // Disabled only when the port really carries stacking headers
  assign stack_ok = !(stack_dis_q && stack_hdr_q[frame.egress_port]);

  always_comb begin
    case (frame.action)
      ACT_EXTRACT, ACT_UP_ENDPOINT_EXTRACT, ACT_LOOPBACK_ASSEMBLE: begin
        point_ok = (frame.pipeline_point >= xtr_pt);
      end
      ACT_INJECT, ACT_QUEUE_LOOPBACK: begin
        point_ok = (frame.pipeline_point <= inj_pt);
      end
      ACT_LATE_REWRITE_EXTRACT: point_ok = 1'b0;
      default: point_ok = 1'b1;
    endcase
  end

  assign svc_hit = frame.valid && phys_port && !frame.abort && mode_ok &&
                   point_ok && stack_ok;
  // Any egress number counts, virtual and CPU ports included
  assign port_hit = frame.valid && !frame.abort &&
                    !is_extract_type(frame.action);
  // Queue aborts always count; OAM discards stay outside the enable
  assign abort_hit = frame.valid && frame.abort &&
                     ((frame.abort_src == ABORT_QUEUE) ||
                      (abort_ena_q &&
                       (frame.abort_src == ABORT_LOOKUP ||
                        frame.abort_src == ABORT_SW_POINT)));

  // Port slot: port times 17, then colour and priority or the abort slot
  assign port_base = {1'b0, frame.egress_port, 4'h0} +
                     PORT_IDX_W'(frame.egress_port);
  assign port_idx = port_base + (frame.abort ? PORT_IDX_W'(ABORT_SLOT) :
                    PORT_IDX_W'({svc_colour, frame.priority_level}));

  // ************************
  // Registered outputs
  // ************************
  logic [LEN_W-1:0] len_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_count <= 1'b0;
      service_count <= 1'b0;
      abort_count <= 1'b0;
      port_count_index <= '0;
      service_count_index <= '0;
      len_q <= '0;
    end else begin
      port_count <= port_hit;
      service_count <= svc_hit;
      abort_count <= abort_hit;
      port_count_index <= port_idx;
      service_count_index <= {svc_colour, svc_idx};
      len_q <= frame.frame_len;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_protection_active <= 1'b0;
      sel_encapsulation_index <= '0;
      sel_maintenance_endpoint_index <= '0;
      sel_service_counter_base <= '0;
    end else if (frame.valid) begin
      key_protection_active <= frame.protection_active_flag;
      sel_encapsulation_index <= use_alt ? lookup.alt_encapsulation_index :
                                 lookup.encapsulation_index;
      sel_maintenance_endpoint_index <= use_alt ?
        lookup.alt_maintenance_endpoint_index :
        lookup.maintenance_endpoint_index;
      sel_service_counter_base <= base_sel;
    end
  end

  // ************************
  // Counter banks
  // ************************
  essi_update_s port_upd;
  essi_update_s svc_upd;
  logic [OCTET_W-1:0] port_oct;
  logic [FRAME_W-1:0] port_frm;
  logic [OCTET_W-1:0] svc_oct;
  logic [FRAME_W-1:0] svc_frm;
  logic port_clr;
  logic svc_clr;

  // Port and abort share one bank; a frame never asks for both
  assign port_upd = '{port_count || abort_count,
                      SVC_IDX_W'(port_count_index), len_q};
  assign svc_upd = '{service_count, service_count_index, len_q};

  essi_counter_bank #(
    .DEPTH(PORT_CNT_DEPTH),
    .IDX_W(PORT_IDX_W)
  ) u_port_bank (
    .clk(clk),
    .reset_n(reset_n),
    .upd(port_upd),
    .rd_index(cnt_sel_q[PORT_IDX_W-1:0]),
    .rd_octets(port_oct),
    .rd_frames(port_frm),
    .clearing(port_clr)
  );

  essi_counter_bank #(
    .DEPTH(SVC_CNT_DEPTH),
    .IDX_W(SVC_IDX_W)
  ) u_svc_bank (
    .clk(clk),
    .reset_n(reset_n),
    .upd(svc_upd),
    .rd_index(cnt_sel_q[SVC_IDX_W-1:0]),
    .rd_octets(svc_oct),
    .rd_frames(svc_frm),
    .clearing(svc_clr)
  );

  // ************************
  // Register read
  // ************************
  logic [OCTET_W-1:0] sel_oct;
  logic [FRAME_W-1:0] sel_frm;
  logic [31:0] rd_mux;
  logic [3:0] pidx;

  assign sel_oct = cnt_sel_q[CS_BANK_BIT] ? svc_oct : port_oct;
  assign sel_frm = cnt_sel_q[CS_BANK_BIT] ? svc_frm : port_frm;
  assign pidx = reg_addr[3:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_port_config(reg_addr)) begin
      rd_mux[PC_XTR_LSB +: PT_W] = xtr_point_q[pidx];
      rd_mux[PC_INJ_LSB +: PT_W] = inj_point_q[pidx];
      rd_mux[PC_STACK_HDR_BIT] = stack_hdr_q[pidx];
    end else begin
      case (reg_addr)
        ADDR_COUNTER_CONTROL: begin
          rd_mux[CC_MODE_LSB +: 2] = mode_q;
          rd_mux[CC_STACK_DIS_BIT] = stack_dis_q;
          rd_mux[CC_ABORT_ENA_BIT] = abort_ena_q;
        end
        ADDR_DROP_LEVEL_COLOUR_MAP: rd_mux[3:0] = drop_map_q;
        ADDR_CLASS_OFFSET_TABLE: rd_mux = class_offset_q;
        ADDR_STATUS: rd_mux[1:0] = {svc_clr, port_clr};
        ADDR_COUNTER_SELECT: rd_mux[12:0] = cnt_sel_q;
        ADDR_COUNTER_FRAMES: rd_mux = sel_frm;
        ADDR_COUNTER_OCTETS_LO: rd_mux = sel_oct[31:0];
        ADDR_COUNTER_OCTETS_HI: rd_mux[7:0] = sel_oct[39:32];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : essi_index_select

`default_nettype wire

/* File: rtl/essi_pkg.sv */
// Package for the egress statistics index selector: register map, field
// layout, reset values, frame and lookup carriers, action encodings.
// Assumes one switch core clock domain and a plain register port.
`default_nettype none

package essi_pkg;

  // ************************
  // Sizes
  // ************************
  localparam int unsigned PORT_W = 4;
  localparam int unsigned PHYS_PORTS = 11;
  localparam int unsigned PORT_CNT_PER = 17;
  localparam int unsigned PORT_CNT_DEPTH = 272;
  localparam int unsigned PORT_IDX_W = 9;
  localparam int unsigned SVC_CNT_DEPTH = 2048;
  localparam int unsigned SVC_IDX_W = 11;
  localparam int unsigned SVC_BASE_W = 10;
  localparam int unsigned OCTET_W = 40;
  localparam int unsigned FRAME_W = 32;
  localparam int unsigned LEN_W = 14;
  localparam int unsigned PT_W = 5;
  localparam int unsigned ABORT_SLOT = 16;

  // ************************
  // Register map (word addresses)
  // ************************
  localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DROP_LEVEL_COLOUR_MAP = 8'h01;
  localparam logic [7:0] ADDR_CLASS_OFFSET_TABLE = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_COUNTER_SELECT = 8'h04;
  localparam logic [7:0] ADDR_COUNTER_FRAMES = 8'h05;
  localparam logic [7:0] ADDR_COUNTER_OCTETS_LO = 8'h06;
  localparam logic [7:0] ADDR_COUNTER_OCTETS_HI = 8'h07;
  localparam logic [7:0] ADDR_PORT_CONFIG_BASE = 8'h10;

  // counter_control fields
  localparam int unsigned CC_MODE_LSB = 0;
  localparam int unsigned CC_STACK_DIS_BIT = 2;
  localparam int unsigned CC_ABORT_ENA_BIT = 3;
  // port_config fields
  localparam int unsigned PC_XTR_LSB = 0;
  localparam int unsigned PC_INJ_LSB = 5;
  localparam int unsigned PC_STACK_HDR_BIT = 10;
  // counter_select fields
  localparam int unsigned CS_BANK_BIT = 12;

  // Reset values
  localparam logic [31:0] COUNTER_CONTROL_RST = 32'h0000_0000;
  localparam logic [3:0] DROP_MAP_RST = 4'h0;
  localparam logic [31:0] CLASS_OFFSET_RST = 32'h0000_0000;
  localparam logic [PT_W-1:0] XTR_POINT_RST = 5'h00;
  localparam logic [PT_W-1:0] INJ_POINT_RST = 5'h1f;

  // ************************
  // Types
  // ************************
  typedef enum logic [2:0] {
    ACT_NONE,
    ACT_INJECT,
    ACT_QUEUE_LOOPBACK,
    ACT_EXTRACT,
    ACT_LATE_REWRITE_EXTRACT,
    ACT_UP_ENDPOINT_EXTRACT,
    ACT_LOOPBACK_ASSEMBLE
  } essi_action_e;

  typedef enum logic [1:0] {
    ABORT_QUEUE,
    ABORT_LOOKUP,
    ABORT_SW_POINT,
    ABORT_OAM
  } essi_abort_src_e;

  typedef struct packed {
    logic valid;
    logic [PORT_W-1:0] egress_port;
    logic [2:0] priority_level;
    logic [2:0] class_id;
    logic [1:0] drop_precedence;
    logic [11:0] ingress_service_index;
    logic [11:0] classified_vid;
    logic tag_pushed;
    logic [11:0] pushed_vid;
    logic routed;
    logic [11:0] router_leg_egress_vlan;
    logic [47:0] dmac;
    essi_action_e action;
    logic [PT_W-1:0] pipeline_point;
    logic abort;
    essi_abort_src_e abort_src;
    logic [LEN_W-1:0] frame_len;
    logic protection_active_flag;
  } essi_frame_s;

  typedef struct packed {
    logic enabled;
    logic protection_sel;
    logic [SVC_BASE_W-1:0] service_counter_base;
    logic [SVC_BASE_W-1:0] alt_service_counter_base;
    logic [11:0] encapsulation_index;
    logic [11:0] alt_encapsulation_index;
    logic [9:0] maintenance_endpoint_index;
    logic [9:0] alt_maintenance_endpoint_index;
  } essi_lookup_s;

  typedef struct packed {
    logic valid;
    logic [SVC_IDX_W-1:0] index;
    logic [LEN_W-1:0] frame_len;
  } essi_update_s;

endpackage : essi_pkg

`default_nettype wire

/* File: rtl/essi_counter_bank.sv */
// Bank of paired octet and frame counters with one update port and one
// asynchronous read port. Clears itself after reset.
// Assumes at most one update per cycle; updates during the clear sweep
// are dropped.
`default_nettype none

module essi_counter_bank
  import essi_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned IDX_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire essi_update_s upd,
  input wire logic [IDX_W-1:0] rd_index,
  output logic [OCTET_W-1:0] rd_octets,
  output logic [FRAME_W-1:0] rd_frames,
  output logic clearing
);

  logic [OCTET_W-1:0] octets_q [DEPTH];
  logic [FRAME_W-1:0] frames_q [DEPTH];
  logic [IDX_W-1:0] clr_idx_q;
  logic clearing_q;
  logic [IDX_W-1:0] upd_idx;

  assign upd_idx = upd.index[IDX_W-1:0];
  assign clearing = clearing_q;
  assign rd_octets = octets_q[rd_index];
  assign rd_frames = frames_q[rd_index];

  // ************************
  // Clear sweep
  // ************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clr_idx_q <= '0;
      clearing_q <= 1'b1;
    end else if (clearing_q) begin
      clr_idx_q <= clr_idx_q + 1'b1;
      if (clr_idx_q == IDX_W'(DEPTH - 1)) begin
        clearing_q <= 1'b0;
      end
    end
  end

  // ************************
  // Counter update
  // ************************
  always_ff @(posedge clk) begin
    if (clearing_q) begin
      octets_q[clr_idx_q] <= '0;
      frames_q[clr_idx_q] <= '0;
    end else if (upd.valid) begin
      // Both halves move in the same cycle so a reader never sees a split
      octets_q[upd_idx] <= octets_q[upd_idx] + OCTET_W'(upd.frame_len);
      frames_q[upd_idx] <= frames_q[upd_idx] + 1'b1;
    end
  end

endmodule : essi_counter_bank

`default_nettype wire

/* File: verif/essi_frame_source.sv */
// Model of the upstream frame pipeline: one frame and lookup per cycle.
// Assumes the bench loads it by non-blocking assignment after an edge.
`default_nettype none

module essi_frame_source
  import essi_pkg::*;
(
  input wire essi_frame_s f_in,
  input wire essi_lookup_s l_in,
  output var essi_frame_s frame,
  output var essi_lookup_s lookup
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle cycles show inverted leftovers, so stale fields never match
  always_comb begin
    frame = f_in;
    lookup = l_in;
    if (!f_in.valid) begin
      frame = ~f_in;
      frame.valid = 1'b0;
      lookup = ~l_in;
    end
  end
endmodule : essi_frame_source

`default_nettype wire

/* File: verif/essi_index_select_sva.sv */
// Checker for the egress statistics index selector.
// Assumes binding to the top module; sees its ports only.
`default_nettype none

module essi_index_select_sva
  import essi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire essi_frame_s frame,
  input wire essi_lookup_s lookup,
  input wire logic [SVC_BASE_W-1:0] sel_service_counter_base,
  input wire logic key_protection_active,
  input wire logic [11:0] sel_encapsulation_index,
  input wire logic [9:0] sel_maintenance_endpoint_index,
  input wire logic port_count,
  input wire logic [PORT_IDX_W-1:0] port_count_index,
  input wire logic service_count,
  input wire logic abort_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic tx;
  assign tx = frame.valid && !frame.abort;
  logic alt;
  assign alt = lookup.protection_sel && frame.protection_active_flag;

  a_abort_no_port: assert property (
    frame.valid && frame.abort |=> !port_count) else $error("port on abort");
  a_port_all: assert property (
    tx && frame.action < ACT_EXTRACT |=> port_count) else $error("no port");
  a_port_index: assert property (
    tx && frame.action < ACT_EXTRACT |=> ((port_count_index -
    9'd17 * 9'($past(frame.egress_port))) & 9'h1f7) ==
    9'($past(frame.priority_level))) else $error("port index");
  a_late_no_svc: assert property (
    frame.valid && frame.action == ACT_LATE_REWRITE_EXTRACT
    |=> !service_count) else $error("late extract counted");
  a_virt_no_svc: assert property (
    frame.valid && frame.egress_port >= PHYS_PORTS |=> !service_count)
    else $error("virtual port counted");
  a_queue_abort: assert property (
    frame.valid && frame.abort && frame.abort_src == ABORT_QUEUE
    |=> abort_count) else $error("queue abort missed");
  a_oam_abort: assert property (
    frame.valid && frame.abort_src == ABORT_OAM |=> !abort_count)
    else $error("oam abort counted");
  a_prot_base: assert property (
    frame.valid && alt |=> sel_service_counter_base ==
    $past(lookup.alt_service_counter_base)) else $error("alternate base");
  a_prot_key: assert property (
    frame.valid |=> key_protection_active ==
    $past(frame.protection_active_flag)) else $error("protection key");
  a_prot_index: assert property (
    frame.valid |=> {sel_encapsulation_index, sel_maintenance_endpoint_index}
    == $past(alt ? {lookup.alt_encapsulation_index,
    lookup.alt_maintenance_endpoint_index} : {lookup.encapsulation_index,
    lookup.maintenance_endpoint_index})) else $error("protection index");
endmodule : essi_index_select_sva

bind essi_index_select essi_index_select_sva i_essi_index_select_sva (
  .clk(clk), .reset_n(reset_n), .frame(frame), .lookup(lookup),
  .sel_service_counter_base(sel_service_counter_base),
  .key_protection_active(key_protection_active),
  .sel_encapsulation_index(sel_encapsulation_index),
  .sel_maintenance_endpoint_index(sel_maintenance_endpoint_index),
  .port_count(port_count), .port_count_index(port_count_index),
  .service_count(service_count), .abort_count(abort_count));

`default_nettype wire

/* File: verif/essi_index_select_tb.sv */
// Bench for the egress statistics index selector: random frames checked
// against a reference of the count decisions, plus counter readback.
// Assumes the frame source model and the bound checker.
`default_nettype none

module essi_index_select_tb
  import essi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  essi_frame_s f_in = '0;
  essi_lookup_s l_in = '0;
  essi_frame_s frame;
  essi_lookup_s lookup;
  logic pcnt, scnt, acnt;
  logic [8:0] pidx;
  logic [10:0] sidx;
  logic [31:0] seed = 32'h4f34;
  logic [3:0] cc = 4'h0;
  logic [3:0] dmap = 4'h0;
  logic [31:0] offs = 32'h0;
  logic [10:0] pcfg [16];
  logic [22:0] e = '0;
  int miscompares = 0;
  int num_checks = 0;

  essi_frame_source i_essi_frame_source (.f_in(f_in), .l_in(l_in),
    .frame(frame), .lookup(lookup));
  essi_index_select i_essi_index_select (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .frame(frame),
    .lookup(lookup), .key_protection_active(),
    .sel_encapsulation_index(), .sel_maintenance_endpoint_index(),
    .sel_service_counter_base(), .port_count(pcnt),
    .port_count_index(pidx), .service_count(scnt),
    .service_count_index(sidx), .abort_count(acnt));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [22:0] ex(essi_frame_s f, essi_lookup_s l);
    logic [9:0] b, x;
    logic c, av, ok, sv, pc, ac;
    b = (l.protection_sel && f.protection_active_flag) ?
      l.alt_service_counter_base : l.service_counter_base;
    av = l.enabled && b != 10'h0;
    c = cc[1] ? f.dmac[40] : dmap[f.drop_precedence];
    if (cc[1:0] == 2'h2)
      x = f.ingress_service_index[9:0];
    else if (cc[1])
      x = f.routed ? f.router_leg_egress_vlan[9:0] :
        f.tag_pushed ? f.pushed_vid[9:0] : f.classified_vid[9:0];
    else
      x = av ? b + 10'(offs[4*f.class_id +: 4]) :
        f.ingress_service_index[9:0];
    case (f.action)
      ACT_INJECT, ACT_QUEUE_LOOPBACK: begin
        ok = f.pipeline_point <= pcfg[f.egress_port][9:5];
      end
      ACT_LATE_REWRITE_EXTRACT: ok = 1'b0;
      ACT_NONE: ok = 1'b1;
      default: ok = f.pipeline_point >= pcfg[f.egress_port][4:0];
    endcase
    sv = f.valid && !f.abort && f.egress_port < PHYS_PORTS && ok &&
      !(cc[1:0] == 2'h1 && !av) && !(cc[2] && pcfg[f.egress_port][10]);
    pc = f.valid && !f.abort && f.action < ACT_EXTRACT;
    ac = f.valid && f.abort &&
      (f.abort_src == ABORT_QUEUE || (f.abort_src != ABORT_OAM && cc[3]));
    return {ac, sv, sv ? {c, x} : 11'h0, pc, (pc || ac) ?
      9'(f.egress_port * 17 + (ac ? 16 : {c, f.priority_level})) : 9'h0};
  endfunction : ex

  function automatic essi_frame_s rf();
    logic [159:0] r;
    essi_frame_s f;
    r = {xs(), xs(), xs(), xs(), xs()};
    f = essi_frame_s'(r[$bits(essi_frame_s)-1:0]);
    f.valid = 1'b1;
    f.abort = r[159:158] == 2'h0;
    if (f.action > ACT_LOOPBACK_ASSEMBLE)
      f.action = ACT_NONE;
    return f;
  endfunction : rf

  function automatic essi_lookup_s rl();
    logic [95:0] r;
    essi_lookup_s l;
    r = {xs(), xs(), xs()};
    l = essi_lookup_s'(r[$bits(essi_lookup_s)-1:0]);
    // A zero base must be hit often to reach the fallback index
    if (r[95:94] == 2'h0) begin
      l.service_counter_base = '0;
      l.alt_service_counter_base = '0;
    end
    return l;
  endfunction : rl

  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rdv(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rdv

  task automatic rd(logic [7:0] a, logic [31:0] x);
    logic [31:0] v;
    rdv(a, v);
    chk("register", v, x);
  endtask : rd

  // Outputs of the previous frame are checked at the edge that loads this
  task automatic step(essi_frame_s f, essi_lookup_s l);
    logic [22:0] o;
    @(posedge clk);
    f_in <= f;
    l_in <= l;
    #1 o = {acnt, scnt, scnt ? sidx : 11'h0, pcnt,
      (pcnt | acnt) ? pidx : 9'h0};
    chk("colour", o[20], e[20]);
    chk("sidx", o[19:10], e[19:10]);
    chk("svc", o[21], e[21]);
    chk("cnt", {o[22], o[9]}, {e[22], e[9]});
    chk("pidx", o[8:0], e[8:0]);
    e = ex(f, l);
  endtask : step

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    logic [31:0] v;
    essi_frame_s f;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_COUNTER_CONTROL, 32'h0);
    rd(ADDR_PORT_CONFIG_BASE, 32'h3e0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    v = 32'h1;
    for (int i = 0; i < 2000 && v != 32'h0; i++) rdv(ADDR_STATUS, v);
    chk("clear", v, 32'h0);
    if (v !== 32'h0) wrap_up();
    f = '0;
    f.valid = 1'b1;
    f.egress_port = 4'h3;
    f.priority_level = 3'h5;
    f.frame_len = 14'h123;
    step(f, '0);
    step(f, '0);
    f.abort = 1'b1;
    step(f, '0);
    step('0, '0);
    wr(ADDR_COUNTER_SELECT, 32'd56);
    rd(ADDR_COUNTER_FRAMES, 32'h2);
    rd(ADDR_COUNTER_OCTETS_LO, 32'h246);
    rd(ADDR_COUNTER_OCTETS_HI, 32'h0);
    wr(ADDR_COUNTER_SELECT, 32'd67);
    rd(ADDR_COUNTER_FRAMES, 32'h1);
    for (int r = 0; r < 8; r++) begin
      cc = (r < 4) ? 4'(r) : 4'(xs());
      dmap = 4'(xs());
      offs = xs();
      wr(ADDR_COUNTER_CONTROL, 32'(cc));
      rd(ADDR_COUNTER_CONTROL, 32'(cc));
      wr(ADDR_DROP_LEVEL_COLOUR_MAP, 32'(dmap));
      wr(ADDR_CLASS_OFFSET_TABLE, offs);
      for (int p = 0; p < 16; p++) begin
        pcfg[p] = 11'(xs());
        wr(ADDR_PORT_CONFIG_BASE + 8'(p), 32'(pcfg[p]));
      end
      repeat (80) step(rf(), rl());
      step('0, '0);
    end
    wrap_up();
  end
endmodule : essi_index_select_tb

`default_nettype wire
